// file: framer_pkg.sv
package framer_pkg;

    // Three-level select encodings; code 2'h3 is treated as HIGH, except by the status mode select, which treats it as MID.
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] MASK_OFS = 4'h8;
    localparam logic [3:0] ALIGN_OFS = 4'hc;

    // Status and mask bit positions.
    localparam int unsigned EV_TX_PAR_ERR = 0;
    localparam int unsigned EV_REALIGN = 1;
    localparam int unsigned EV_FRAME_HIT = 2;
    localparam int unsigned EV_COUNT = 3;

    // Field positions in the alignment status register.
    localparam int unsigned ALIGN_OFS_LSB = 0;
    localparam int unsigned ALIGN_LOCK_BIT = 4;

    // Framing patterns, first received bit in bit 9.
    localparam logic [9:0] K285_NEG = 10'h0fa;
    localparam logic [9:0] K285_POS = 10'h305;
    localparam logic [7:0] COMMA_NEG = 8'h3e;
    localparam logic [7:0] COMMA_POS = 8'hc1;

    // Receive status codes of the two reporting modes.
    localparam logic [2:0] ST_A_DATA = 3'h0;
    localparam logic [2:0] ST_A_HIT = 3'h1;
    localparam logic [2:0] ST_A_REALIGN = 3'h3;
    localparam logic [2:0] ST_B_DATA = 3'h0;
    localparam logic [2:0] ST_B_HIT = 3'h2;
    localparam logic [2:0] ST_B_REALIGN = 3'h5;

    // Framer defaults: window of five characters, four adjacent hits.
    localparam int unsigned WIN_CHARS_DEF = 5;
    localparam int unsigned ADJ_HITS_DEF = 4;

    // Configuration word; every select resets to MID, the floating level.
    typedef struct packed {
        logic [1:0] tx_encode_mode_sel;
        logic [1:0] decoder_mode_sel;
        logic [1:0] rx_status_mode_sel;
        logic [1:0] parity_control_sel;
        logic [1:0] reframe_mode_sel;
        logic [1:0] framing_char_sel;
    } ctrl_t;
    localparam logic [11:0] CTRL_RESET = 12'h555;

    // One parallel transmit character with its parity.
    typedef struct packed {
        logic tx_odd_parity_in;
        logic [1:0] tx_control_in;
        logic [7:0] data;
    } tx_word_t;

    // Framer result for one character time.
    typedef struct packed {
        logic [9:0] char_bits;
        logic valid;
        logic realign;
        logic hit;
        logic [3:0] offset;
        logic locked;
    } frame_out_t;

    typedef struct packed {
        logic [9:0] prev;
        logic [3:0] cand_off;
        logic cand_ok;
        logic [2:0] age;
        logic [2:0] run;
        frame_out_t out;
    } framer_state_t;

    typedef struct packed {
        ctrl_t ctrl;
        logic [EV_COUNT-1:0] status;
        logic [EV_COUNT-1:0] mask;
        logic [31:0] rdata;
        logic waitreq;
        logic [2:0] en_sync;
        logic reframe_enable;
        logic [7:0] rx_data;
        logic [2:0] rx_status_out;
        logic rx_odd_parity_out;
        logic rx_parity_oe_n;
        logic rx_valid;
        logic irq;
    } top_state_t;

endpackage

// file: parity_unit.sv
`timescale 1ns/1ps
`default_nettype none
module parity_unit import framer_pkg::*; (
    // Configuration.
    input wire logic [1:0] parity_control_sel_i,
    input wire logic enc_bypass_i,
    input wire logic dec_bypass_i,
    // Transmit character to check.
    input wire tx_word_t tx_word_i,
    // Receive character to cover.
    input wire logic [7:0] rx_data_i,
    input wire logic [2:0] rx_status_out_i,
    // Results.
    output logic tx_error_o,
    output logic rx_odd_parity_out_o,
    output logic rx_drive_o
);
    logic both_bypassed;
    logic [10:0] tx_bits;
    logic [10:0] rx_bits;

    // Odd parity: covered bits plus parity bit hold an odd count of ones.
    always_comb begin
        both_bypassed = enc_bypass_i && dec_bypass_i;
        tx_bits = {2'h0, tx_word_i.tx_odd_parity_in, tx_word_i.data};
        rx_bits = {3'h0, rx_data_i};
        if (parity_control_sel_i == SEL_MID && both_bypassed) begin
            tx_bits[10:9] = tx_word_i.tx_control_in;
            rx_bits[9:8] = rx_status_out_i[1:0];
        end else if (parity_control_sel_i != SEL_LOW && parity_control_sel_i != SEL_MID) begin
            tx_bits[10:9] = tx_word_i.tx_control_in;
            rx_bits[10:8] = rx_status_out_i;
        end
        rx_drive_o = parity_control_sel_i != SEL_LOW;
        tx_error_o = rx_drive_o && !(^tx_bits);
        rx_odd_parity_out_o = ~(^rx_bits);
    end
endmodule // parity_unit
`default_nettype wire

// file: framer_aligner.sv
`timescale 1ns/1ps
`default_nettype none
module framer_aligner import framer_pkg::*; #(
    parameter int unsigned WIN_CHARS = WIN_CHARS_DEF,
    parameter int unsigned ADJ_HITS = ADJ_HITS_DEF
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Unaligned ten-bit words from the deserialiser.
    input wire logic [9:0] rx_bits_i,
    input wire logic rx_bits_valid_i,
    // Configuration.
    input wire logic reframe_enable_i,
    input wire logic [1:0] framing_char_sel_i,
    input wire logic [1:0] reframe_mode_sel_i,
    // Result.
    output frame_out_t frame_o
);
    // The age and run counters are three bits wide.
    if (WIN_CHARS < 2 || WIN_CHARS > 7 || ADJ_HITS < 2 || ADJ_HITS > 7) begin : g_check
        $error("framer_aligner: window or hit count out of range");
    end

    framer_state_t s;
    framer_state_t next_s;
    logic [19:0] win;
    logic [9:0] hit;

    assign win = {s.prev, rx_bits_i};

    // One comparator pair per bit offset of the two-word window.
    for (genvar k = 0; k < 10; k++) begin : g_off
        logic [9:0] w;
        assign w = win[19-k -: 10];
        assign hit[k] = (framing_char_sel_i == SEL_MID) ?
            (w[9:2] == COMMA_NEG || w[9:2] == COMMA_POS) :
            (w == K285_NEG || w == K285_POS);
    end

    always_comb begin
        logic [3:0] first;
        logic [2:0] age_now;
        logic [2:0] run_now;
        logic move;
        first = 4'h0;
        age_now = 3'(s.age + 3'h1);
        run_now = 3'h1;
        move = 1'b0;
        next_s = s;
        next_s.out.valid = 1'b0;
        next_s.out.realign = 1'b0;
        next_s.out.hit = 1'b0;
        for (int i = 9; i >= 0; i--) begin
            if (hit[i]) begin
                first = 4'(i);
            end
        end
        if (rx_bits_valid_i) begin
            next_s.prev = rx_bits_i;
            if (s.cand_ok && age_now > 3'(WIN_CHARS - 1)) begin
                next_s.cand_ok = 1'b0;
            end else begin
                next_s.age = age_now;
            end
            if (!reframe_enable_i) begin
                next_s.cand_ok = 1'b0;
                next_s.run = 3'h0;
            end else if (|hit) begin
                next_s.out.hit = 1'b1;
                unique case (reframe_mode_sel_i)
                    SEL_LOW: begin
                        move = 1'b1;
                    end
                    SEL_MID: begin
                        if (s.cand_ok && s.cand_off == first && age_now <= 3'(WIN_CHARS - 1)) begin
                            move = 1'b1;
                            next_s.cand_ok = 1'b0;
                        end else begin
                            next_s.cand_ok = 1'b1;
                            next_s.cand_off = first;
                            next_s.age = 3'h0;
                        end
                    end
                    default: begin
                        if (s.run != 3'h0 && s.cand_off == first) begin
                            run_now = 3'(s.run + 3'h1);
                        end
                        next_s.cand_off = first;
                        next_s.run = run_now;
                        if (run_now >= 3'(ADJ_HITS)) begin
                            move = 1'b1;
                            next_s.run = 3'h0;
                        end
                    end
                endcase
            end else begin
                next_s.run = 3'h0;
            end
            if (move) begin
                next_s.out.locked = 1'b1;
                if (first != s.out.offset) begin
                    next_s.out.offset = first;
                    next_s.out.realign = 1'b1;
                end
            end
            next_s.out.char_bits = win[19 - next_s.out.offset -: 10];
            // Multi-byte modes keep the character strobe phase; the low-latency
            // mode stretches it by one character time on each boundary move.
            next_s.out.valid = !(next_s.out.realign && reframe_mode_sel_i == SEL_LOW);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign frame_o = s.out;
endmodule // framer_aligner
`default_nettype wire

// file: rx_framer_parity_control.sv
// Behaviour
// - Status mode select ignored when decoder bypassed.
// - Framing select MID: find both comma polarities.
// - Framing select HIGH: find both full symbols.
// - Reframe LOW: realign on every detection.
// - Low-latency realign stretches the character strobe.
// - Reframe MID: two hits within five characters.
// - Reframe HIGH: four adjacent hits, same offset.
// - Parity LOW: no check, parity pin undriven.
// - Parity MID, codecs on: eight data bits.
// - Parity MID, codecs bypassed: add control/status.
// - Parity HIGH: data, control, all status bits.
// - Boundaries move only while reframe enable high.
// - Decoder LOW: raw ten-bit characters delivered.
`timescale 1ns/1ps
`default_nettype none
module rx_framer_parity_control import framer_pkg::*; #(
    parameter int unsigned WIN_CHARS = WIN_CHARS_DEF,
    parameter int unsigned ADJ_HITS = ADJ_HITS_DEF
) (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Avalon-MM register slave.
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Interrupt.
    output logic irq_o,
    // Reframe enable pin, asynchronous.
    input wire logic reframe_enable_i,
    // Serial receive path, one unaligned ten-bit word per strobe.
    input wire logic [9:0] rx_bits_i,
    input wire logic rx_bits_valid_i,
    // Parallel transmit interface from the host.
    input wire tx_word_t tx_word_i,
    input wire logic tx_valid_i,
    // Parallel receive interface to the host.
    output logic [7:0] rx_data_o,
    output logic [2:0] rx_status_out_o,
    output logic rx_valid_o,
    output logic rx_odd_parity_out_o,
    output logic rx_parity_oe_n_o
);
    top_state_t s;
    top_state_t next_s;
    frame_out_t frame;
    logic tx_error;
    logic rx_par;
    logic rx_drive;
    logic dec_bypass;
    logic enc_bypass;
    logic [7:0] next_rx_data;
    logic [2:0] next_rx_status;

    // Bypass flags follow from the codec selects.
    assign dec_bypass = s.ctrl.decoder_mode_sel == SEL_LOW;
    assign enc_bypass = s.ctrl.tx_encode_mode_sel == SEL_LOW;

    // The framer runs from the synchronised enable and the current selects.
    // Selects are assumed static while the link carries traffic, so no
    // attempt is made to flush partial hit counts when they change.
    framer_aligner #(
        .WIN_CHARS(WIN_CHARS),
        .ADJ_HITS(ADJ_HITS)
    ) u_framer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .rx_bits_i(rx_bits_i),
        .rx_bits_valid_i(rx_bits_valid_i),
        .reframe_enable_i(s.reframe_enable),
        .framing_char_sel_i(s.ctrl.framing_char_sel),
        .reframe_mode_sel_i(s.ctrl.reframe_mode_sel),
        .frame_o(frame)
    );

    // Receive character and status as they will leave on the next edge.
    // The symbol tables are outside this block, so in decoded modes the
    // low eight framed bits are passed on and the status carries framer
    // events coded per reporting mode.
    always_comb begin
        next_rx_data = frame.char_bits[7:0];
        next_rx_status = ST_A_DATA;
        if (dec_bypass) begin
            next_rx_status = {1'b0, frame.char_bits[9:8]};
        end else if (s.ctrl.rx_status_mode_sel == SEL_HIGH) begin
            if (frame.realign) begin
                next_rx_status = ST_B_REALIGN;
            end else if (frame.hit) begin
                next_rx_status = ST_B_HIT;
            end else begin
                next_rx_status = ST_B_DATA;
            end
        end else begin
            if (frame.realign) begin
                next_rx_status = ST_A_REALIGN;
            end else if (frame.hit) begin
                next_rx_status = ST_A_HIT;
            end else begin
                next_rx_status = ST_A_DATA;
            end
        end
    end

    // Parity covers the character that is about to be registered, so the
    // parity pin and the data pins change on the same edge.
    parity_unit u_parity (
        .parity_control_sel_i(s.ctrl.parity_control_sel),
        .enc_bypass_i(enc_bypass),
        .dec_bypass_i(dec_bypass),
        .tx_word_i(tx_word_i),
        .rx_data_i(next_rx_data),
        .rx_status_out_i(next_rx_status),
        .tx_error_o(tx_error),
        .rx_odd_parity_out_o(rx_par),
        .rx_drive_o(rx_drive)
    );

    // Byte-lane mask for register writes.
    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        return m;
    endfunction

    // Register read multiplexer; unmapped offsets read as zero.
    function automatic logic [31:0] read_word(input top_state_t st, input frame_out_t fr, input logic [3:0] adr);
        logic [31:0] d;
        d = '0;
        unique case (adr)
            CTRL_OFS: d[11:0] = st.ctrl;
            STAT_OFS: d[EV_COUNT-1:0] = st.status;
            MASK_OFS: d[EV_COUNT-1:0] = st.mask;
            ALIGN_OFS: begin
                d[ALIGN_OFS_LSB +: 4] = fr.offset;
                d[ALIGN_LOCK_BIT] = fr.locked;
            end
            default: d = '0;
        endcase
        return d;
    endfunction

    always_comb begin
        logic req;
        logic take;
        logic [31:0] wmask;
        logic [EV_COUNT-1:0] events;
        logic [EV_COUNT-1:0] clr;
        req = avs_read_i || avs_write_i;
        take = req && !s.waitreq;
        wmask = lane_mask(avs_byteenable_i);
        events = '0;
        clr = '0;
        next_s = s;

        // Bus handshake: every request waits one cycle, then is taken on the
        // edge at which waitrequest is seen low. Read data is prepared during
        // the wait cycle so that it already stands when the edge arrives.
        if (req && s.waitreq) begin
            next_s.waitreq = 1'b0;
            next_s.rdata = avs_read_i ? read_word(s, frame, avs_address_i) : 32'h0;
        end else begin
            next_s.waitreq = 1'b1;
        end

        // Register writes honour byte enables.
        if (take && avs_write_i) begin
            unique case (avs_address_i)
                CTRL_OFS: begin
                    next_s.ctrl = (s.ctrl & ~wmask[11:0]) | (avs_writedata_i[11:0] & wmask[11:0]);
                end
                MASK_OFS: begin
                    next_s.mask = (s.mask & ~wmask[EV_COUNT-1:0]) |
                        (avs_writedata_i[EV_COUNT-1:0] & wmask[EV_COUNT-1:0]);
                end
                STAT_OFS: begin
                    clr = avs_writedata_i[EV_COUNT-1:0] & wmask[EV_COUNT-1:0];
                end
                default: begin
                end
            endcase
        end

        // Three-stage synchroniser for the reframe enable pin; a new level
        // counts only once the second and third stages agree.
        next_s.en_sync = {s.en_sync[1:0], reframe_enable_i};
        if (s.en_sync[1] == s.en_sync[2]) begin
            next_s.reframe_enable = s.en_sync[2];
        end

        // Sticky events: a new event wins over a write-one clear.
        events[EV_TX_PAR_ERR] = tx_valid_i && tx_error;
        events[EV_REALIGN] = frame.realign;
        events[EV_FRAME_HIT] = frame.hit;
        next_s.status = (s.status & ~clr) | events;
        next_s.irq = |(next_s.status & next_s.mask);

        // Receive output register, loaded once per framed character.
        next_s.rx_valid = frame.valid;
        if (frame.valid) begin
            next_s.rx_data = next_rx_data;
            next_s.rx_status_out = next_rx_status;
            next_s.rx_odd_parity_out = rx_drive ? rx_par : 1'b0;
        end
        // Output enable is active low: released at once when parity is off.
        next_s.rx_parity_oe_n = !rx_drive;
    end

    // All state registers on one edge; reset gives every select MID.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s <= '0;
            s.ctrl <= CTRL_RESET;
            s.waitreq <= 1'b1;
            s.rx_parity_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Every output comes straight from a state flip-flop.
    assign avs_readdata_o = s.rdata;
    assign avs_waitrequest_o = s.waitreq;
    assign irq_o = s.irq;
    assign rx_data_o = s.rx_data;
    assign rx_status_out_o = s.rx_status_out;
    assign rx_valid_o = s.rx_valid;
    assign rx_odd_parity_out_o = s.rx_odd_parity_out;
    assign rx_parity_oe_n_o = s.rx_parity_oe_n;
endmodule // rx_framer_parity_control
`default_nettype wire

// file: framer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module framer_checker import framer_pkg::*; (
    // Clock, reset and bus.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // Interrupt and receive side.
    input wire logic irq_o,
    input wire logic rx_bits_valid_i,
    input wire logic [7:0] rx_data_o,
    input wire logic [2:0] rx_status_out_o,
    input wire logic rx_valid_o,
    input wire logic rx_odd_parity_out_o,
    input wire logic rx_parity_oe_n_o
);
    ctrl_t sh;
    logic done;
    logic byp;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Shadow of the configuration word.
    assign done = avs_write_i && !avs_waitrequest_o;
    assign byp = sh.decoder_mode_sel == SEL_LOW && sh.tx_encode_mode_sel == SEL_LOW;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sh <= ctrl_t'(CTRL_RESET);
        end else if (done && avs_address_i == CTRL_OFS) begin
            sh <= ctrl_t'(avs_writedata_i[11:0]);
        end
    end
    wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("wait too long");
    answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("no answer");
    unmapped_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[1:0] != 2'h0
        |-> avs_readdata_o == 32'h0) else $error("unmapped read");
    irq_mask_a: assert property (done && avs_address_i == MASK_OFS && avs_writedata_i[2:0] == 3'h0
        |=> ##1 !irq_o) else $error("irq masked");
    rx_pulse_a: assert property (rx_valid_o |-> $past(rx_bits_valid_i, 2)) else $error("stray rx valid");
    oe_follow_a: assert property (
        !$past(rst_i) && $stable(sh) |-> rx_parity_oe_n_o == (sh.parity_control_sel == SEL_LOW))
        else $error("parity enable");
    par_mid_a: assert property (
        rx_valid_o && sh.parity_control_sel == SEL_MID && !byp |-> ^{rx_odd_parity_out_o, rx_data_o})
        else $error("mid parity wrong");
    par_byp_a: assert property (rx_valid_o && sh.parity_control_sel == SEL_MID && byp
        |-> ^{rx_odd_parity_out_o, rx_status_out_o[1:0], rx_data_o}) else $error("bypass parity wrong");
    par_high_a: assert property (rx_valid_o && sh.parity_control_sel == SEL_HIGH
        |-> ^{rx_odd_parity_out_o, rx_status_out_o, rx_data_o}) else $error("high parity wrong");
    byp_status_a: assert property (rx_valid_o && sh.decoder_mode_sel == SEL_LOW
        |-> rx_status_out_o[2] == 1'b0) else $error("bypass status");
endmodule // framer_checker
bind rx_framer_parity_control framer_checker u_framer_checker (
    .clk_sys_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .irq_o, .rx_bits_valid_i, .rx_data_o, .rx_status_out_o, .rx_valid_o,
    .rx_odd_parity_out_o, .rx_parity_oe_n_o);
`default_nettype wire

// file: serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Character to send and its bit shift.
    input wire logic send_i,
    input wire logic [9:0] char_i,
    input wire logic [3:0] shift_i,
    // Deserialised words towards the framer.
    output logic [9:0] rx_bits_o,
    output logic rx_bits_valid_o
);
    logic [9:0] last_char;
    logic [19:0] pair;
    assign pair = {last_char, char_i} >> shift_i;
    // Stale words toggle between strobes.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            last_char <= 10'h0;
            rx_bits_o <= 10'h0;
            rx_bits_valid_o <= 1'b0;
        end else if (send_i) begin
            last_char <= char_i;
            rx_bits_o <= pair[9:0];
            rx_bits_valid_o <= 1'b1;
        end else begin
            rx_bits_o <= ~rx_bits_o;
            rx_bits_valid_o <= 1'b0;
        end
    end
endmodule // serial_host_model
`default_nettype wire

// file: rx_framer_parity_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rx_framer_parity_control_tb import framer_pkg::*; ;
    localparam logic [1:0] L = SEL_LOW;
    localparam logic [1:0] M = SEL_MID;
    localparam logic [1:0] H = SEL_HIGH;
    localparam logic [9:0] F = 10'h2aa;
    localparam logic [9:0] K = K285_NEG;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] adr;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic wreq;
    logic irq;
    logic rf_en = 1'b1;
    logic [9:0] bits;
    logic bvalid;
    tx_word_t txw;
    logic txv = 1'b0;
    logic [7:0] rxd;
    logic [2:0] rxs;
    logic rxv;
    logic oe_n;
    logic send = 1'b0;
    logic [9:0] chr;
    logic [3:0] shift;
    logic [7:0] last_d;
    logic [2:0] last_s;
    logic [31:0] v;
    int errors = 0;
    int checks = 0;
    int pulses = 0;
    int cycles = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    rx_framer_parity_control #(.WIN_CHARS(5), .ADJ_HITS(4)) u_rx_framer_parity_control (.clk_sys_i, .rst_i,
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .irq_o(irq),
        .reframe_enable_i(rf_en), .rx_bits_i(bits), .rx_bits_valid_i(bvalid), .tx_word_i(txw),
        .tx_valid_i(txv), .rx_data_o(rxd), .rx_status_out_o(rxs), .rx_valid_o(rxv),
        .rx_odd_parity_out_o(), .rx_parity_oe_n_o(oe_n));
    serial_host_model u_serial_host_model (.clk_sys_i, .rst_i, .send_i(send), .char_i(chr),
        .shift_i(shift), .rx_bits_o(bits), .rx_bits_valid_o(bvalid));
    // Cycle ceiling and capture of delivered characters.
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (rxv === 1'b1) begin
            pulses <= pulses + 1;
            last_d <= rxd;
            last_s <= rxs;
        end
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        do @(posedge clk_sys_i); while (wreq !== 1'b0);
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(v, exp);
    endtask
    task automatic chk_irq(input logic exp);
        repeat (3) @(posedge clk_sys_i);
        check({31'h0, irq}, {31'h0, exp});
    endtask
    function automatic logic [31:0] mk(input logic [1:0] fc, rf, pc, sm, dc, en);
        return {20'h0, en, dc, sm, pc, rf, fc};
    endfunction
    // Selects change with the link idle; framing never LOW.
    task automatic cfg(input logic [31:0] c);
        bus(1'b1, CTRL_OFS, c);
        bus(1'b1, STAT_OFS, 32'h7);
    endtask
    task automatic send_seq(input logic [9:0] s[$]);
        foreach (s[i]) begin
            @(posedge clk_sys_i);
            send <= 1'b1;
            chr <= s[i];
        end
        @(posedge clk_sys_i);
        send <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic frame_case(input logic [31:0] c, input logic [3:0] k, input logic [9:0] s[$],
                              input logic [4:0] al, input logic re, output int n);
        int p0;
        cfg(c);
        shift <= k;
        p0 = pulses;
        send_seq(s);
        n = pulses - p0;
        rd_chk(ALIGN_OFS, {27'h0, al});
        bus(1'b0, STAT_OFS, 32'h0);
        check({31'h0, v[1]}, {31'h0, re});
    endtask
    task automatic t_reset();
        rd_chk(CTRL_OFS, 32'h555);
        rd_chk(STAT_OFS, 32'h0);
        rd_chk(MASK_OFS, 32'h0);
        rd_chk(ALIGN_OFS, 32'h0);
        bus(1'b1, ALIGN_OFS, 32'h1f);
        rd_chk(ALIGN_OFS, 32'h0);
        rd_chk(4'h2, 32'h0);
    endtask
    task automatic t_txpar();
        logic [31:0] c[5] = '{mk(H, M, L, M, M, M), mk(H, M, M, M, M, M), mk(H, M, M, M, M, L),
                              mk(H, M, M, M, L, L), mk(H, M, H, M, M, M)};
        logic [4:0] e = 5'h18;
        for (int i = 0; i < 5; i++) begin
            cfg(c[i]);
            txw <= '{tx_odd_parity_in: 1'b0, tx_control_in: 2'h1, data: 8'h01};
            txv <= 1'b1;
            @(posedge clk_sys_i);
            txv <= 1'b0;
            rd_chk(STAT_OFS, {31'h0, e[i]});
            check({31'h0, oe_n}, {31'h0, i == 0});
        end
        bus(1'b1, MASK_OFS, 32'h1);
        chk_irq(1'b1);
        bus(1'b1, MASK_OFS, 32'h0);
        chk_irq(1'b0);
        bus(1'b1, MASK_OFS, 32'h1);
        bus(1'b1, STAT_OFS, 32'h1);
        chk_irq(1'b0);
        rd_chk(STAT_OFS, 32'h0);
    endtask
    task automatic t_lowlat();
        logic [9:0] kc[5] = '{10'h0f8, 10'h0f8, 10'h304, K285_POS, K285_NEG};
        logic [1:0] fc[5] = '{H, M, M, H, H};
        logic [3:0] k[5] = '{4'h4, 4'h4, 4'h6, 4'h2, 4'h7};
        logic [4:0] al[5] = '{5'h00, 5'h14, 5'h16, 5'h12, 5'h17};
        int n;
        for (int i = 0; i < 5; i++) begin
            frame_case(mk(fc[i], L, M, M, M, M), k[i], '{F, kc[i], F, F, F}, al[i], i != 0, n);
            check({31'h0, n == 5}, {31'h0, i == 0});
        end
    endtask
    task automatic t_multi();
        int n;
        frame_case(mk(H, M, M, M, M, M), 4'h8, '{K, F, F, F, F, K, F, F, F, F, F}, 5'h17, 1'b0, n);
        frame_case(mk(H, M, M, M, M, M), 4'h8, '{K, F, F, F, K, F}, 5'h18, 1'b1, n);
        frame_case(mk(H, H, M, M, M, M), 4'h3, '{K, K, K, F, K, K, K, F}, 5'h18, 1'b0, n);
        frame_case(mk(H, H, M, M, M, M), 4'h3, '{K, K, K, K, F}, 5'h13, 1'b1, n);
        rf_en <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        frame_case(mk(H, L, M, M, M, M), 4'h1, '{K, F, K, F, F}, 5'h13, 1'b0, n);
        rf_en <= 1'b1;
    endtask
    task automatic t_bypass();
        int n;
        frame_case(mk(H, M, M, H, L, L), 4'h3, '{F, 10'h2a5, F}, 5'h13, 1'b0, n);
        check({24'h0, last_d}, 32'ha5);
        check({29'h0, last_s}, 32'h2);
        frame_case(mk(H, M, H, M, L, L), 4'h3, '{F, 10'h2a5, F}, 5'h13, 1'b0, n);
        check({29'h0, last_s}, 32'h2);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_txpar();
        t_lowlat();
        t_multi();
        t_bypass();
        give_verdict();
    end
endmodule // rx_framer_parity_control_tb
`default_nettype wire
